// ---- srx_link_rx.sv ----
// Purpose: link layer of an eight-lane serial receiver with register file
// Assumes: lane quads arrive decoded, on core_clk, one quad per lane per cycle
// Notes: transport output is built for link 0, logical lane 0
//Contract
//- 12-bit mode: three octets carry conv0 then conv1 nibbles, MSB first
//- 16-bit mode: four octets carry conv0 high, low, then conv1 high, low
//- interface stays powered down until power register bit 0 is cleared
//- lane power-down bit x set turns lane x off
//- termination calibration starts by itself when interface is configured
//- byte rate is lane rate over ten; processing clock is byte rate over four
//- frames per processing cycle equal four over octets per frame
//- lane rate follows converters, lanes, bits per sample and data rate
//- each deserializer channel delivers 40-bit parallel words
//- lane PLL dividers chosen from mode and interpolation settings
//- PLL lock shows as bit 0 of PLL status register
//- lane PLL covers whole lane rate range without gaps
//- sampling phase recovered per lane from lane PLL clocks
//- per-lane 2-bit boost, 2-bit gain and 5-bit feedback controls
//- each link requests sync by driving its sync output low
//- four consecutive commas release sync at next multiframe clock edge
//- after release, lanes align on the align to lane-start transition
//- elastic buffers hold early lanes and release all together
//- control characters mark frames and align lanes
//- one or two links; all lanes run synchronization and alignment
//- lane data passes lane buffer, crossbar, deframer, descrambler in order; no descrambler is built here
//- counted comma is control character K28.5
//- deframer handles four octets per lane every processing cycle
`timescale 1ns/1ps
`include "srx_regs.svh"

module srx_link_rx
    import srx_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic [11:0]       reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    output logic [7:0]             reg_rdata,
    input  wire logic              pll_lock_in,
    input  srx_quad_t [7:0]        serial_lane_input,
    output logic [1:0]             link_sync_request_out,
    output logic [7:0]             lane_power_down_bits,
    output logic                   serdes_power_on,
    output logic                   term_cal_start,
    output logic [15:0]            pll_div_sel,
    output logic [15:0]            eq_boost,
    output logic [15:0]            eq_gain,
    output logic [39:0]            eq_feedback,
    output srx_out_t               out_data,
    output logic                   out_valid,
    input  wire logic              out_ready
);
    // register file storage
    logic [7:0]  mode_reg, interp_reg, pwr_reg, pd_reg, ctrl_reg;
    logic [7:0]  boost_lo_reg, boost_hi_reg, gain_lo_reg, gain_hi_reg;
    logic [4:0]  fb_reg [8];
    logic        lock_meta_reg, lock_reg;
    logic        pwr_on_prev_reg;
    // link and lane state
    srx_state_t  state_reg [2];
    srx_state_t  state_next [2];
    logic [2:0]  kcnt_reg [8];
    logic [7:0]  last_a_reg, started_reg;
    logic [5:0]  lmfc_reg;
    logic        ovf_reg;
    logic [31:0] mem [8][4];
    logic [2:0]  wptr_reg [8], rptr_reg [8];
    // deframer residue and output buffer
    logic [15:0] res_reg;
    logic [1:0]  rcnt_reg;
    srx_out_t    q1_reg;
    logic [1:0]  qcnt_reg;

    wire dual   = ctrl_reg[`SRX_CTRL_DUAL];
    wire twelve = ctrl_reg[`SRX_CTRL_TWELVE];
    wire pwr_on = ~pwr_reg[0];

    // link number of a physical lane; crossbar is identity here
    function automatic logic lane_link(input logic [2:0] lane, input logic d);
        return d & lane[2];
    endfunction

    // unpack one frame from three or four octets
    function automatic srx_frame_t unpack(input logic [31:0] o, input logic t);
        srx_frame_t f;
        if (t) begin
            f.conv0 = {4'h0, o[7:0], o[15:12]};
            f.conv1 = {4'h0, o[11:8], o[23:16]};
        end else begin
            f.conv0 = {o[7:0], o[15:8]};
            f.conv1 = {o[23:16], o[31:24]};
        end
        return f;
    endfunction

    // register writes; ctrl defaults to one 16-bit link, disabled
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mode_reg     <= `SRX_RST_ZERO;
            interp_reg   <= `SRX_RST_ZERO;
            pwr_reg      <= `SRX_RST_PWR;
            pd_reg       <= `SRX_RST_ZERO;
            ctrl_reg     <= `SRX_RST_ZERO;
            boost_lo_reg <= `SRX_RST_ZERO;
            boost_hi_reg <= `SRX_RST_ZERO;
            gain_lo_reg  <= `SRX_RST_ZERO;
            gain_hi_reg  <= `SRX_RST_ZERO;
            for (int i = 0; i < 8; i++) fb_reg[i] <= 5'h00;
        end else if (reg_wr) begin
            case (reg_addr)
                `SRX_OFS_PLL_MODE:   mode_reg     <= reg_wdata;
                `SRX_OFS_PLL_INTERP: interp_reg   <= reg_wdata;
                `SRX_OFS_PWR:        pwr_reg      <= reg_wdata;
                `SRX_OFS_LANE_PD:    pd_reg       <= reg_wdata;
                `SRX_OFS_BOOST_LO:   boost_lo_reg <= reg_wdata;
                `SRX_OFS_BOOST_HI:   boost_hi_reg <= reg_wdata;
                `SRX_OFS_GAIN_LO:    gain_lo_reg  <= reg_wdata;
                `SRX_OFS_GAIN_HI:    gain_hi_reg  <= reg_wdata;
                `SRX_OFS_CTRL:       ctrl_reg     <= reg_wdata;
                default: begin
                    if (reg_addr >= `SRX_OFS_FB0 && reg_addr <= `SRX_OFS_FB7) begin
                        fb_reg[reg_addr[2:0] - 3'h4] <= reg_wdata[4:0];
                    end
                end
            endcase
        end
    end

    // register reads, one cycle latency; unmapped addresses read zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= `SRX_RST_ZERO;
        end else begin
            case (reg_addr)
                `SRX_OFS_PLL_MODE:   reg_rdata <= mode_reg;
                `SRX_OFS_PLL_INTERP: reg_rdata <= interp_reg;
                `SRX_OFS_PWR:        reg_rdata <= pwr_reg;
                `SRX_OFS_LANE_PD:    reg_rdata <= pd_reg;
                `SRX_OFS_BOOST_LO:   reg_rdata <= boost_lo_reg;
                `SRX_OFS_BOOST_HI:   reg_rdata <= boost_hi_reg;
                `SRX_OFS_GAIN_LO:    reg_rdata <= gain_lo_reg;
                `SRX_OFS_GAIN_HI:    reg_rdata <= gain_hi_reg;
                `SRX_OFS_PLL_STAT:   reg_rdata <= {7'h00, lock_reg};
                `SRX_OFS_CTRL:       reg_rdata <= ctrl_reg;
                `SRX_OFS_LINK_STAT:  reg_rdata <= {ovf_reg, 3'h0, state_reg[1] == SRX_ST_DATA,
                                                   state_reg[0] == SRX_ST_DATA, link_sync_request_out};
                default: begin
                    if (reg_addr >= `SRX_OFS_FB0 && reg_addr <= `SRX_OFS_FB7) begin
                        reg_rdata <= {3'h0, fb_reg[reg_addr[2:0] - 3'h4]};
                    end else begin
                        reg_rdata <= `SRX_RST_ZERO;
                    end
                end
            endcase
        end
    end

    // pll lock comes from the analog macro, so it is synchronised first
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lock_meta_reg <= 1'b0;
            lock_reg      <= 1'b0;
        end else begin
            lock_meta_reg <= pll_lock_in;
            lock_reg      <= lock_meta_reg;
        end
    end

    // analog controls, all straight from flops
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lane_power_down_bits <= 8'hFF;
            serdes_power_on      <= 1'b0;
            term_cal_start       <= 1'b0;
            pwr_on_prev_reg      <= 1'b0;
            pll_div_sel          <= 16'h0000;
            eq_boost             <= 16'h0000;
            eq_gain              <= 16'h0000;
            eq_feedback          <= 40'h00_0000_0000;
        end else begin
            // a powered-down interface forces every lane off
            lane_power_down_bits <= pd_reg | {8{~pwr_on}};
            serdes_power_on      <= pwr_on;
            pwr_on_prev_reg      <= pwr_on;
            // calibration fires on power-up with no host write needed
            term_cal_start       <= pwr_on & ~pwr_on_prev_reg;
            // the PLL divides dac clock by four and picks dividers from these
            pll_div_sel          <= {interp_reg, mode_reg};
            eq_boost             <= {boost_hi_reg, boost_lo_reg};
            eq_gain              <= {gain_hi_reg, gain_lo_reg};
            for (int i = 0; i < 8; i++) eq_feedback[i*5 +: 5] <= fb_reg[i];
        end
    end

    // multiframe clock: 32 frames of F octets, four octets per cycle
    wire [5:0] lmfc_last = twelve ? 6'd23 : 6'd31;
    wire       lmfc_edge = (lmfc_reg == 6'd0);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lmfc_reg <= 6'd0;
        end else begin
            lmfc_reg <= (lmfc_reg >= lmfc_last) ? 6'd0 : lmfc_reg + 6'd1;
        end
    end

    // per-lane comma run counter; a lane that is off never counts
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) kcnt_reg[i] <= 3'h0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                srx_quad_t q;
                q = serial_lane_input[i];
                if (lane_power_down_bits[i] || state_reg[lane_link(3'(i), dual)] == SRX_ST_IDLE) begin
                    kcnt_reg[i] <= 3'h0;
                end else if (&q.k && q.data == {4{`SRX_K_COMMA}}) begin
                    kcnt_reg[i] <= `SRX_CGS_RUN;
                end else if (state_reg[lane_link(3'(i), dual)] == SRX_ST_CGS) begin
                    kcnt_reg[i] <= 3'h0;
                end
            end
        end
    end

    // per-link completion flags over member lanes that are powered
    logic [1:0] cgs_ok, all_started;
    always_comb begin
        cgs_ok      = 2'b11;
        all_started = 2'b11;
        for (int i = 0; i < 8; i++) begin
            if (!lane_power_down_bits[i]) begin
                if (kcnt_reg[i] != `SRX_CGS_RUN) cgs_ok[lane_link(3'(i), dual)] = 1'b0;
                if (!started_reg[i]) all_started[lane_link(3'(i), dual)] = 1'b0;
            end
        end
        if (!dual) begin
            cgs_ok[1]      = 1'b0;
            all_started[1] = 1'b0;
        end
    end

    // link state machines; link 1 idles unless two links are chosen
    wire link_go = ctrl_reg[`SRX_CTRL_ENABLE] & pwr_on & lock_reg;
    always_comb begin
        for (int l = 0; l < 2; l++) begin
            state_next[l] = state_reg[l];
            if (!link_go || (l == 1 && !dual)) begin
                state_next[l] = SRX_ST_IDLE;
            end else begin
                case (state_reg[l])
                    SRX_ST_IDLE: state_next[l] = SRX_ST_CGS;
                    SRX_ST_CGS:  if (cgs_ok[l] && lmfc_edge) state_next[l] = SRX_ST_ILAS;
                    SRX_ST_ILAS: if (all_started[l]) state_next[l] = SRX_ST_DATA;
                    SRX_ST_DATA: state_next[l] = SRX_ST_DATA;
                    default:     state_next[l] = SRX_ST_IDLE;
                endcase
            end
        end
    end

    // sync output low while idle or hunting commas
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg[0]          <= SRX_ST_IDLE;
            state_reg[1]          <= SRX_ST_IDLE;
            link_sync_request_out <= 2'b00;
        end else begin
            for (int l = 0; l < 2; l++) begin
                state_reg[l] <= state_next[l];
                link_sync_request_out[l] <= (state_next[l] == SRX_ST_ILAS) ||
                                            (state_next[l] == SRX_ST_DATA);
            end
        end
    end

    // lane start detection: an align char ends one quad, lane-start opens the next
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            last_a_reg  <= 8'h00;
            started_reg <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                srx_quad_t q;
                q = serial_lane_input[i];
                last_a_reg[i] <= q.k[3] && q.data[31:24] == `SRX_K_ALIGN;
                if (state_reg[lane_link(3'(i), dual)] != SRX_ST_ILAS &&
                    state_reg[lane_link(3'(i), dual)] != SRX_ST_DATA) begin
                    started_reg[i] <= 1'b0;
                end else if (last_a_reg[i] && q.k[0] && q.data[7:0] == `SRX_K_LANE_START) begin
                    started_reg[i] <= 1'b1;
                end
            end
        end
    end

    // elastic buffers: write from the lane start, read all at once
    logic [7:0] wr_en, rd_en;
    logic       push_ok;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            logic lk;
            lk = lane_link(3'(i), dual);
            wr_en[i] = ~lane_power_down_bits[i] & (started_reg[i] |
                       (last_a_reg[i] & serial_lane_input[i].k[0] &
                        serial_lane_input[i].data[7:0] == `SRX_K_LANE_START)) &
                       (state_reg[lk] == SRX_ST_ILAS || state_reg[lk] == SRX_ST_DATA);
            // only link 0 lanes see transport stall; link 1 drains freely
            rd_en[i] = started_reg[i] & (state_reg[lk] == SRX_ST_DATA) &
                       (wptr_reg[i] != rptr_reg[i]) & (lk | push_ok);
        end
    end

    // four-deep lanes absorb up to two cycles of skew; overflow is sticky
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) begin
                wptr_reg[i] <= 3'h0;
                rptr_reg[i] <= 3'h0;
            end
            ovf_reg <= 1'b0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (!wr_en[i] && !started_reg[i]) begin
                    wptr_reg[i] <= 3'h0;
                    rptr_reg[i] <= 3'h0;
                end else begin
                    // a read in the same cycle frees the slot being written
                    if (wr_en[i] && ((wptr_reg[i] - rptr_reg[i]) != 3'h4 || rd_en[i])) begin
                        wptr_reg[i] <= wptr_reg[i] + 3'h1;
                    end else if (wr_en[i]) begin
                        ovf_reg <= 1'b1;
                    end
                    if (rd_en[i]) rptr_reg[i] <= rptr_reg[i] + 3'h1;
                end
            end
        end
    end

    // lane buffer storage has no reset
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < 8; i++) begin
            if (wr_en[i]) mem[i][wptr_reg[i][1:0]] <= serial_lane_input[i].data;
        end
    end

    // deframer on logical lane 0: residue plus four new octets per cycle
    logic [47:0] oct;
    logic [2:0]  noct;
    srx_out_t    dfr;
    always_comb begin
        logic [47:0] w;
        w    = {16'h0000, mem[0][rptr_reg[0][1:0]]};
        oct  = (w << {rcnt_reg, 3'b000}) | {32'h0000_0000, res_reg};
        noct = {1'b0, rcnt_reg} + 3'h4;
        dfr  = '0;
        dfr.f0 = unpack(oct[31:0], twelve);
        dfr.f1 = unpack({8'h00, oct[47:24]}, twelve);
        if (!twelve) begin
            dfr.count = 2'd1;
        end else begin
            dfr.count = (noct == 3'd6) ? 2'd2 : 2'd1;
        end
    end

    // residue keeps the octets of a 12-bit frame that spans two quads
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            res_reg  <= 16'h0000;
            rcnt_reg <= 2'd0;
        end else if (state_reg[0] != SRX_ST_DATA) begin
            res_reg  <= 16'h0000;
            rcnt_reg <= 2'd0;
        end else if (rd_en[0] && twelve) begin
            rcnt_reg <= (noct == 3'd6) ? 2'd0 : noct[1:0] + 2'd1;
            res_reg  <= (noct == 3'd6) ? 16'h0000 : (noct == 3'd4) ? {8'h00, oct[31:24]} : oct[39:24];
        end
    end

    // two-entry output buffer; head entry is the output flop itself
    assign push_ok = (qcnt_reg != 2'd2) | out_ready; // full buffer still takes a word while one drains
    wire   push    = rd_en[0];
    wire   pop     = out_valid & out_ready;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            out_data  <= '0;
            q1_reg    <= '0;
            qcnt_reg  <= 2'd0;
            out_valid <= 1'b0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (qcnt_reg == 2'd0) out_data <= dfr;
                    else q1_reg <= dfr;
                    qcnt_reg  <= qcnt_reg + 2'd1;
                    out_valid <= 1'b1;
                end
                2'b01: begin
                    out_data  <= q1_reg;
                    qcnt_reg  <= qcnt_reg - 2'd1;
                    out_valid <= (qcnt_reg == 2'd2);
                end
                2'b11: begin
                    // stall-free pass: new word takes the drained head when one is held, else the second entry
                    if (qcnt_reg == 2'd1) out_data <= dfr;
                    else begin
                        out_data <= q1_reg;
                        q1_reg   <= dfr;
                    end
                end
                default: begin
                    out_valid <= (qcnt_reg != 2'd0);
                end
            endcase
        end
    end
endmodule

// ---- srx_regs.svh ----
// Purpose: register offsets, reset values and counts of the lane receiver
// Assumes: 12-bit register address, 8-bit register data
// Notes: included by the receiver module only
`ifndef SRX_REGS_SVH
`define SRX_REGS_SVH
`define SRX_OFS_PLL_MODE   12'h110
`define SRX_OFS_PLL_INTERP 12'h111
`define SRX_OFS_PWR        12'h200
`define SRX_OFS_LANE_PD    12'h201
`define SRX_OFS_BOOST_LO   12'h240
`define SRX_OFS_BOOST_HI   12'h241
`define SRX_OFS_GAIN_LO    12'h242
`define SRX_OFS_GAIN_HI    12'h243
`define SRX_OFS_FB0        12'h244
`define SRX_OFS_FB7        12'h24B
`define SRX_OFS_PLL_STAT   12'h281
`define SRX_OFS_CTRL       12'h2F0
`define SRX_OFS_LINK_STAT  12'h2F1
`define SRX_RST_PWR        8'h01
`define SRX_RST_ZERO       8'h00
`define SRX_CTRL_DUAL      0
`define SRX_CTRL_TWELVE    1
`define SRX_CTRL_ENABLE    2
`define SRX_K_COMMA        8'hBC
`define SRX_K_ALIGN        8'h7C
`define SRX_K_LANE_START   8'h1C
`define SRX_CGS_RUN        3'h4
`define SRX_FRAMES_PER_MF  6'h08
`endif

// ---- srx_pkg.sv ----
// Purpose: types shared by the lane receiver and its testbench
// Assumes: four octets per lane per processing clock
// Notes: octet 0 of a quad sits in bits [7:0]
package srx_pkg;
    typedef enum logic [3:0] {
        SRX_ST_IDLE = 4'b0001,
        SRX_ST_CGS  = 4'b0010,
        SRX_ST_ILAS = 4'b0100,
        SRX_ST_DATA = 4'b1000
    } srx_state_t;
    typedef struct packed {
        logic [3:0]  k;
        logic [31:0] data;
    } srx_quad_t;
    typedef struct packed {
        logic [15:0] conv1;
        logic [15:0] conv0;
    } srx_frame_t;
    typedef struct packed {
        logic [1:0]  count;
        srx_frame_t  f1;
        srx_frame_t  f0;
    } srx_out_t;
endpackage

// ---- srx_link_rx_sva.sv ----
// Purpose: protocol checks on the lane receiver ports
// Assumes: single clock core_clk, async active-high rst
// Notes: register outputs show a write two edges after it is taken
`timescale 1ns/1ps
module srx_link_rx_sva
    import srx_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input srx_quad_t [7:0]  serial_lane_input,
    input wire logic [1:0]  link_sync_request_out,
    input wire logic [7:0]  lane_power_down_bits,
    input wire logic        serdes_power_on,
    input wire logic        term_cal_start,
    input wire logic [15:0] eq_boost,
    input wire logic [39:0] eq_feedback,
    input srx_out_t         out_data,
    input wire logic        out_valid,
    input wire logic        out_ready
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // power, calibration and lane enables
    a_pd_all_off: assert property (!serdes_power_on |-> lane_power_down_bits == 8'hFF)
        else $error("lanes on while interface down");
    a_pd_lane_map: assert property (reg_wr && reg_addr == 12'h201 && serdes_power_on
        |-> ##2 lane_power_down_bits == $past(reg_wdata, 2))
        else $error("lane power-down bits do not follow register");
    a_cal_pulse: assert property ($rose(serdes_power_on) |-> term_cal_start ##1 !term_cal_start)
        else $error("no single calibration pulse at power-up");
    a_cal_cause: assert property (term_cal_start |-> serdes_power_on)
        else $error("calibration while powered down");
    // equalizer fields reach the lanes
    a_eq_boost: assert property (reg_wr && reg_addr == 12'h240 |-> ##2 eq_boost[7:0] == $past(reg_wdata, 2))
        else $error("boost field mismatch");
    a_eq_fb: assert property (reg_wr && reg_addr == 12'h244
        |-> ##2 {3'b000, eq_feedback[4:0]} == ($past(reg_wdata, 2) & 8'h1F))
        else $error("feedback field mismatch");
    // sync release needs power and a full comma quad
    a_sync_power: assert property (link_sync_request_out != 2'b00 |-> serdes_power_on)
        else $error("sync released while powered down");
    a_sync_comma: assert property ($rose(link_sync_request_out[0])
        |-> $past(serial_lane_input[0]) == {4'hF, 32'hBCBC_BCBC})
        else $error("sync released without commas");
    // a stalled word stays put
    a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("output word lost under stall");
endmodule

bind srx_link_rx srx_link_rx_sva u_sva (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .serial_lane_input,
    .link_sync_request_out, .lane_power_down_bits, .serdes_power_on, .term_cal_start, .eq_boost, .eq_feedback,
    .out_data, .out_valid, .out_ready);

// ---- srx_tx_model.sv ----
// Purpose: transmitter stand-in feeding decoded quads to all eight lanes
// Assumes: mode 0 idle data, 1 commas, 2 alignment then counting data
// Notes: lanes 1-7 lag lane 0 by one quad so the receiver must hold lane 0
`timescale 1ns/1ps
module srx_tx_model
    import srx_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [1:0] tx_mode,
    output srx_quad_t [7:0] serial_lane_input
);
    logic [7:0] b_reg;
    srx_quad_t  q;
    srx_quad_t  q_d_reg;

    // octet base parks on the align quad until running; wraps after about 58 quads
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            b_reg   <= 8'h18;
            q_d_reg <= '0;
        end else begin
            b_reg   <= (tx_mode == 2'd2) ? b_reg + 8'h04 : 8'h18;
            q_d_reg <= q;
        end
    end

    // idle sends comma bytes without the control flag, so they must not count
    always_comb begin
        if (tx_mode == 2'd1) q = {4'hF, 32'hBCBC_BCBC};
        else if (tx_mode == 2'd0) q = {4'h0, 32'hBCBC_BCBC};
        else if (b_reg == 8'h18) q = {4'h8, 8'h7C, 8'h1A, 8'h19, 8'h18};
        else q = {3'b000, b_reg == 8'h1C, b_reg + 8'h03, b_reg + 8'h02, b_reg + 8'h01, b_reg};
        serial_lane_input = {{7{q_d_reg}}, q};
    end
endmodule

// ---- tb_srx_link_rx.sv ----
// Purpose: register and link bring-up tests of the lane receiver
// Assumes: inputs driven on falling edges, 200 MHz core_clk
// Notes: transport checked for single link, 16-bit and 12-bit modes
`timescale 1ns/1ps
module tb_srx_link_rx
    import srx_pkg::*;
;
    logic             core_clk, rst, reg_wr, pll_lock_in, out_ready;
    logic             serdes_power_on, term_cal_start, out_valid;
    logic [11:0]      reg_addr;
    logic [7:0]       reg_wdata, reg_rdata, lane_power_down_bits, base, prev;
    logic [1:0]       link_sync_request_out, tx_mode;
    logic [15:0]      pll_div_sel, eq_boost, eq_gain;
    logic [39:0]      eq_feedback;
    srx_quad_t [7:0]  serial_lane_input;
    srx_out_t         out_data;
    int               errors, cmp_count, cyc, n;

    srx_link_rx  dut (.*);
    srx_tx_model tx (.core_clk, .rst, .tx_mode, .serial_lane_input);

    // clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        reg_addr = a;
        @(negedge core_clk);
        chk(reg_rdata, exp);
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard, well above the few hundred cycles the tests need
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            close_out();
        end
    end

    // 12-bit frame at stream octet x, nibbles high first
    function automatic logic [31:0] frm12(input logic [7:0] x);
        logic [7:0] y;
        y = x + 8'h01;
        return {4'h0, y[3:0], x + 8'h02, 4'h0, x, y[7:4]};
    endfunction

    // link bring-up, then aligned data through a two-cycle sink stall
    task automatic link_run(input logic t);
        tx_mode = 2'd0;
        wr(12'h2F0, 8'h00);
        wr(12'h2F0, {5'h00, 1'b1, t, 1'b0});
        for (int c = 0; c < 40; c++) begin
            @(negedge core_clk);
            chk(link_sync_request_out, 2'b00);
        end
        tx_mode = 2'd1;
        n = 0;
        while (link_sync_request_out[0] !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        chk(n <= 36, 1'b1);
        chk(link_sync_request_out, 2'b01);
        $display("test sync done");
        tx_mode = 2'd2;
        n = 0;
        prev = 8'h00;
        for (int c = 0; c < 40; c++) begin
            @(negedge core_clk);
            out_ready = !(c == 12 || c == 13);
            if (out_valid === 1'b1 && out_ready) begin
                base = t ? out_data.f0.conv0[11:4] : out_data.f0.conv0[15:8];
                if (n > 0) chk(base, prev);
                if (t) begin
                    chk(out_data.f0, frm12(base));
                    if (out_data.count == 2'd2) chk(out_data.f1, frm12(base + 8'h03));
                    prev = base + ((out_data.count == 2'd2) ? 8'h06 : 8'h03);
                end else begin
                    chk(out_data.f0, {base + 8'h02, base + 8'h03, base, base + 8'h01});
                    chk(out_data.count, 2'd1);
                    prev = base + 8'h04;
                end
                n++;
            end
        end
        chk(n >= 10, 1'b1);
        rchk(12'h2F1, 8'h05);
        $display("test data done");
    endtask

    initial begin
        {rst, reg_wr, pll_lock_in, out_ready, tx_mode, reg_addr, reg_wdata} = {1'b1, 25'd0};
        {errors, cmp_count, cyc} = '0;
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        chk(lane_power_down_bits, 8'hFF);
        rchk(12'h200, 8'h01);
        rchk(12'h201, 8'h00);
        rchk(12'h3FF, 8'h00);
        wr(12'h281, 8'hFF);
        rchk(12'h281, 8'h00);
        $display("test reset done");
        wr(12'h240, 8'hAA);
        wr(12'h241, 8'hFF);
        wr(12'h242, 8'h55);
        wr(12'h243, 8'hFF);
        for (int i = 0; i < 8; i++) wr(12'h244 + 12'(i), 8'h1F);
        rchk(12'h24B, 8'h1F);
        chk({eq_boost, eq_gain}, 32'hFFAA_FF55);
        chk(eq_feedback, 40'hFF_FFFF_FFFF);
        wr(12'h110, 8'h05);
        wr(12'h111, 8'h0C);
        @(negedge core_clk);
        chk(pll_div_sel, 16'h0C05);
        $display("test equalizer done");
        wr(12'h201, 8'h00);
        chk(lane_power_down_bits, 8'hFF);
        wr(12'h200, 8'h00);
        @(negedge core_clk);
        chk({serdes_power_on, term_cal_start, lane_power_down_bits}, 10'h300);
        wr(12'h201, 8'h80);
        @(negedge core_clk);
        chk({term_cal_start, lane_power_down_bits}, 9'h080);
        wr(12'h201, 8'h00);
        pll_lock_in = 1'b1;
        repeat (3) @(negedge core_clk);
        rchk(12'h281, 8'h01);
        $display("test power-up done");
        link_run(1'b0);
        link_run(1'b1);
        close_out();
    end
endmodule
